// >>> inc/amr_pkg.sv
// Constants and types shared by the auto-modem command and data register group.
// Assumes the control bus word decode happens in front of this block.
package amr_pkg;

    // Register addresses on the serial control bus.
    localparam logic [7:0] ADDR_TX_PRIMARY = 8'hE3;
    localparam logic [7:0] ADDR_TX_ALTERNATE = 8'hE4;
    localparam logic [7:0] ADDR_RX_DATA = 8'hE5;
    localparam logic [7:0] ADDR_AM_COMMAND = 8'hEA;

    // Auto-modem command word fields.
    localparam int CMD_FAST_BIT = 5;
    localparam int CMD_OP_MSB = 4;
    localparam int CMD_OP_LSB = 3;
    localparam int CMD_RATE_MSB = 2;
    localparam logic [5:0] CMD_STOP = 6'h00;
    localparam logic [2:0] CMD_RENEG_TOP = 3'h4;
    localparam logic [1:0] OP_RETRAIN = 2'h1;
    localparam logic [1:0] OP_CALL = 2'h2;
    localparam logic [1:0] OP_ANSWER = 2'h3;

    // Maximum bit rate codes, fastest first.
    localparam logic [2:0] RATE_14400 = 3'h7;
    localparam logic [2:0] RATE_12000 = 3'h6;
    localparam logic [2:0] RATE_9600_TRELLIS = 3'h5;
    localparam logic [2:0] RATE_9600_UNCODED = 3'h4;
    localparam logic [2:0] RATE_7200 = 3'h3;
    localparam logic [2:0] RATE_4800 = 3'h2;
    localparam logic [2:0] RATE_2400 = 3'h1;
    localparam logic [2:0] RATE_1200 = 3'h0;

    // Auto-modem progress codes; a connection shows 1000 to 1111.
    localparam logic [3:0] AST_IDLE = 4'h0;
    localparam logic [3:0] AST_STARTUP = 4'h1;
    localparam logic [3:0] AST_RETRAIN = 4'h2;
    localparam logic [3:0] AST_RENEG = 4'h3;
    localparam logic AST_CONNECTED_MSB = 1'b1;

    // Mode register fields used here.
    localparam logic [3:0] MODE_QAM_AUTO = 4'hF;
    localparam int MODE_SEL_MSB = 15;
    localparam int MODE_SEL_LSB = 12;
    localparam int FMT_MSB = 5;
    localparam int FMT_LSB = 3;
    localparam logic [2:0] FMT_SPECIAL = 3'h7;
    localparam logic [2:0] SPECIAL_SYNC = 3'h7;
    localparam logic [2:0] SPECIAL_HDLC = 3'h6;
    localparam logic [3:0] BITS_MIN = 4'h5;
    localparam logic [3:0] BITS_FULL = 4'h8;

    // Transmit parity sense and the room that re-arms transmit ready.
    localparam logic TX_PARITY_ODD = 1'b0;
    localparam int TX_FIFO_DEPTH = 8;
    localparam int TX_FIFO_WIDTH = 9;
    localparam logic [3:0] TX_READY_ROOM = 4'h4;

    // Auto-modem sequencer states.
    typedef enum logic [2:0] {
        AM_IDLE = 3'b000,
        AM_STARTUP = 3'b001,
        AM_CONNECTED = 3'b010,
        AM_RETRAIN = 3'b011,
        AM_RENEG = 3'b100
    } amr_am_state_t;

    // Transmit character framer states.
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_DATA = 3'b001,
        TX_PARITY = 3'b010,
        TX_STOP = 3'b011
    } amr_tx_state_t;

endpackage

// >>> rtl/amr_fifo.sv
// First-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on the one block clock.
module amr_fifo
    import amr_pkg::*;
#(
    parameter int WIDTH = TX_FIFO_WIDTH,
    parameter int DEPTH = TX_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Free entries left.
    output logic [$clog2(DEPTH):0] free
);
    localparam int AW = $clog2(DEPTH);

    // All storage and pointers of the buffer.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } amr_fifo_st_t;

    amr_fifo_st_t s_q;
    amr_fifo_st_t s_d;
    logic push;
    logic pop;

    // Full and empty follow the occupancy count exactly.
    assign in_ready = (s_q.count < (AW + 1)'(DEPTH));
    assign out_valid = (s_q.count != '0);
    assign out_data = s_q.mem[s_q.rd];
    assign free = (AW + 1)'(DEPTH) - s_q.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next state: write on push, advance the read pointer on pop.
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.count = s_q.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // State register.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// >>> rtl/amr_regs.sv
// Auto-modem command register and transmit/receive data registers of the modem.
// Assumes a front end that turns serial bus frames into one-cycle word strobes,
// and a modem datapath on the same clock that paces bits with one-cycle ticks.
//
// Operation
// - Commands ignored unless both modes are auto.
// - Decode stop, retrain, call, answer, re-negotiate.
// - V.22 answer with fast bit drops answer tone.
// - V.32 fast bit selects quick echo training.
// - Three-bit field caps the negotiated rate.
// - Start command runs whole start-up, reports events.
// - Connected status shows rate code 1000..1111.
// - Remote retrain and re-negotiation answered automatically.
// - Sixteen-bit transmit write sends upper byte first.
// - Synchronous transmit sends eight bits LSB first.
// - Start-stop adds start, parity, stop; LSB first.
// - One-character alternate address gives V.14 overspeed.
// - Two-character alternate address sends one lone byte.
// - Receive width change acts only after reset.
// - Sync and HDLC bytes: earliest bit in bit 0.
// - Start-stop bytes right aligned, unused bits zero.
// - HDLC check sequence follows last data character.
// - Transmit ready sets on room, clears on write.
// - Receive ready sets on data, clears on read.
module amr_regs
    import amr_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Register word port.
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_wide,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    // Settings from neighbouring registers.
    input wire logic [15:0] tx_mode_reg,
    input wire logic [15:0] rx_mode_reg,
    input wire logic gen_wide_sel,
    input wire logic gen_reset,
    // Flags toward the status register.
    output logic st_tx_ready,
    output logic st_rx_ready,
    output logic st_rx_overflow,
    output logic st_rx_two_chars,
    // Auto-modem sequencer interface.
    input wire logic dp_v32_family,
    input wire logic dp_train_done,
    input wire logic dp_train_fail,
    input wire logic [2:0] dp_rate,
    input wire logic dp_remote_retrain,
    input wire logic dp_remote_reneg,
    output logic [3:0] am_status,
    output logic am_event,
    output logic [4:0] am_cmd_pulse,
    output logic [2:0] am_rate_cap,
    output logic am_tone_off,
    output logic am_ec_fast,
    // Transmit bit stream.
    input wire logic tx_bit_tick,
    output logic tx_bit,
    // Receive bit stream.
    input wire logic rx_char_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_frame_end
);
    // All state of the register group.
    typedef struct packed {
        amr_am_state_t am;
        logic [2:0] cap;
        logic fast;
        logic [2:0] conn_rate;
        logic tone_off;
        logic ec_fast;
        logic event_p;
        logic [4:0] cmd_p;
        logic [7:0] split_lo;
        logic split_pend;
        logic tx_rdy;
        amr_tx_state_t tx;
        logic [7:0] tx_sh;
        logic [2:0] tx_cnt;
        logic tx_par;
        logic tx_no_stop;
        logic tx_bit;
        logic [7:0] rx_sh;
        logic [3:0] rx_cnt;
        logic [15:0] rx_hold;
        logic rx_half;
        logic rx_rdy;
        logic rx_ovf;
        logic rx_two;
        logic rx_wide;
        logic width_taken;
        logic [15:0] rdata;
    } amr_st_t;

    amr_st_t s_q;
    amr_st_t s_d;

    // Buffer handshakes and decoded strobes.
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [TX_FIFO_WIDTH-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [TX_FIFO_WIDTH-1:0] fifo_out_data;
    logic [3:0] fifo_free;
    logic tx_write;
    logic is_alt;
    logic auto_ok;
    logic [5:0] cmd;
    logic tx_sync;
    logic [2:0] rx_special;
    logic rx_full_byte;
    logic [3:0] rx_nbits;
    logic [7:0] rx_byte;
    logic rx_done;

    // Transmit bytes wait here until the framer takes them.
    amr_fifo #(
        .WIDTH(TX_FIFO_WIDTH),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .free(fifo_free)
    );

    // Command is taken only when both mode selects say auto-modem.
    assign auto_ok = (tx_mode_reg[MODE_SEL_MSB:MODE_SEL_LSB] == MODE_QAM_AUTO)
        && (rx_mode_reg[MODE_SEL_MSB:MODE_SEL_LSB] == MODE_QAM_AUTO);
    assign cmd = bus_wdata[5:0];
    assign tx_write = bus_wr && ((bus_addr == ADDR_TX_PRIMARY) || (bus_addr == ADDR_TX_ALTERNATE));
    assign is_alt = (bus_addr == ADDR_TX_ALTERNATE);
    assign tx_sync = (tx_mode_reg[FMT_MSB:FMT_LSB] == FMT_SPECIAL);

    // A second write cycle is spent pushing a held lower byte.
    assign fifo_in_valid = s_q.split_pend || (tx_write && !s_q.split_pend);
    always_comb begin
        if (s_q.split_pend) begin
            fifo_in_data = {1'b0, s_q.split_lo};
        end else if (gen_wide_sel && !is_alt) begin
            fifo_in_data = {1'b0, bus_wdata[15:8]};
        end else begin
            // The overspeed mark exists only in one-character mode.
            fifo_in_data = {is_alt && !gen_wide_sel, bus_wdata[7:0]};
        end
    end

    // The framer pulls a new byte only on a bit tick while idle.
    assign fifo_out_ready = tx_bit_tick && (s_q.tx == TX_IDLE);

    // Receive framing: special sync and HDLC are full bytes.
    assign rx_special = rx_mode_reg[2:0];
    assign rx_full_byte = (rx_mode_reg[FMT_MSB:FMT_LSB] == FMT_SPECIAL)
        && ((rx_special == SPECIAL_SYNC) || (rx_special == SPECIAL_HDLC));
    assign rx_nbits = rx_full_byte ? BITS_FULL : (BITS_MIN + {2'b00, rx_mode_reg[2:1]});
    assign rx_done = rx_bit_valid && ((s_q.rx_cnt + 4'h1) == rx_nbits);
    // Bits enter at the top, so the earliest ends in bit 0 after alignment.
    assign rx_byte = 8'({rx_bit, s_q.rx_sh[7:1]} >> (BITS_FULL - rx_nbits));

    // Next-state logic for the whole group.
    always_comb begin
        s_d = s_q;
        s_d.event_p = 1'b0;
        s_d.cmd_p = 5'h00;

        // Host command decode; upper ten bits are never looked at.
        if (bus_wr && (bus_addr == ADDR_AM_COMMAND) && auto_ok) begin
            if (cmd == CMD_STOP) begin
                s_d.am = AM_IDLE;
                s_d.cmd_p = 5'h01;
            end else if (cmd[CMD_FAST_BIT:CMD_OP_LSB] == CMD_RENEG_TOP) begin
                s_d.cap = cmd[CMD_RATE_MSB:0];
                s_d.cmd_p = 5'h10;
                if (s_q.am == AM_CONNECTED) begin
                    s_d.am = AM_RENEG;
                end
            end else if (cmd[CMD_OP_MSB:CMD_OP_LSB] == OP_RETRAIN) begin
                s_d.cap = cmd[CMD_RATE_MSB:0];
                s_d.fast = cmd[CMD_FAST_BIT];
                s_d.cmd_p = 5'h02;
                if (s_q.am == AM_CONNECTED) begin
                    s_d.am = AM_RETRAIN;
                end
            end else if (cmd[CMD_OP_MSB]) begin
                // Call and answer both launch the full start-up sequence.
                s_d.am = AM_STARTUP;
                s_d.cap = cmd[CMD_RATE_MSB:0];
                s_d.fast = cmd[CMD_FAST_BIT];
                s_d.cmd_p = cmd[CMD_OP_LSB] ? 5'h08 : 5'h04;
                s_d.tone_off = cmd[CMD_OP_LSB] && cmd[CMD_FAST_BIT]
                    && !dp_v32_family;
            end
        end
        // Fast training reaches echo training only on the V.32 family.
        s_d.ec_fast = s_d.fast && dp_v32_family;

        // Sequencer progress driven by the datapath and the far modem.
        case (s_q.am)
            AM_IDLE: begin
                s_d.tone_off = s_d.tone_off;
            end
            AM_STARTUP, AM_RETRAIN, AM_RENEG: begin
                if (dp_train_done) begin
                    s_d.am = AM_CONNECTED;
                    // A completed training never reports a rate above the host cap.
                    s_d.conn_rate = (dp_rate > s_q.cap) ? s_q.cap : dp_rate;
                end else if (dp_train_fail) begin
                    s_d.am = (s_q.am == AM_RENEG) ? AM_CONNECTED : AM_IDLE;
                end
            end
            AM_CONNECTED: begin
                if (dp_remote_retrain) begin
                    s_d.am = AM_RETRAIN;
                end else if (dp_remote_reneg) begin
                    s_d.am = AM_RENEG;
                end
            end
            default: begin
                s_d.am = AM_IDLE;
            end
        endcase
        s_d.event_p = (s_d.am != s_q.am) || (s_d.conn_rate != s_q.conn_rate);

        // Second half of a sixteen-bit transmit write.
        if (s_q.split_pend) begin
            if (fifo_in_ready) begin
                s_d.split_pend = 1'b0;
            end
        end else if (tx_write && gen_wide_sel && !is_alt && fifo_in_ready) begin
            s_d.split_lo = bus_wdata[7:0];
            s_d.split_pend = 1'b1;
        end

        // Transmit ready: room in the buffer wins over a clearing write.
        if (!s_q.split_pend && (fifo_free >= TX_READY_ROOM)) begin
            s_d.tx_rdy = 1'b1;
        end else if (tx_write) begin
            s_d.tx_rdy = 1'b0;
        end

        // Character framer, one bit per tick.
        if (tx_bit_tick) begin
            case (s_q.tx)
                TX_IDLE: begin
                    s_d.tx_bit = 1'b1;
                    if (fifo_out_valid) begin
                        s_d.tx_par = 1'b0;
                        s_d.tx_no_stop = fifo_out_data[8] && !tx_sync;
                        s_d.tx = TX_DATA;
                        if (tx_sync) begin
                            s_d.tx_bit = fifo_out_data[0];
                            s_d.tx_sh = {1'b0, fifo_out_data[7:1]};
                            s_d.tx_cnt = 3'h6;
                        end else begin
                            s_d.tx_bit = 1'b0;
                            s_d.tx_sh = fifo_out_data[7:0];
                            s_d.tx_cnt = {1'b1, tx_mode_reg[2:1]};
                        end
                    end
                end
                TX_DATA: begin
                    s_d.tx_bit = s_q.tx_sh[0];
                    s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                    s_d.tx_par = s_q.tx_par ^ s_q.tx_sh[0];
                    s_d.tx_cnt = s_q.tx_cnt - 3'h1;
                    if (s_q.tx_cnt == 3'h0) begin
                        if (tx_sync) begin
                            s_d.tx = TX_IDLE;
                        end else if (tx_mode_reg[0]) begin
                            s_d.tx = TX_PARITY;
                        end else begin
                            s_d.tx = s_q.tx_no_stop ? TX_IDLE : TX_STOP;
                        end
                    end
                end
                TX_PARITY: begin
                    s_d.tx_bit = s_q.tx_par ^ TX_PARITY_ODD;
                    s_d.tx = s_q.tx_no_stop ? TX_IDLE : TX_STOP;
                end
                TX_STOP: begin
                    s_d.tx_bit = 1'b1;
                    s_d.tx = TX_IDLE;
                end
                default: begin
                    s_d.tx = TX_IDLE;
                end
            endcase
        end

        // Receive width is sampled once after each reset only.
        if (!s_q.width_taken) begin
            s_d.rx_wide = gen_wide_sel;
            s_d.width_taken = 1'b1;
        end

        // Receive read: hand out the word and clear the flags.
        s_d.rdata = 16'h0000;
        if (bus_rd && (bus_addr == ADDR_RX_DATA)) begin
            s_d.rdata = s_q.rx_hold;
            s_d.rx_rdy = 1'b0;
            s_d.rx_ovf = 1'b0;
        end

        // Receive assembly; a new character wins over a clearing read.
        if (rx_char_start) begin
            s_d.rx_cnt = 4'h0;
            s_d.rx_sh = 8'h00;
        end else if (rx_bit_valid) begin
            s_d.rx_sh = {rx_bit, s_q.rx_sh[7:1]};
            s_d.rx_cnt = rx_done ? 4'h0 : s_q.rx_cnt + 4'h1;
        end
        if (rx_done && !rx_char_start) begin
            if (!s_q.rx_wide) begin
                s_d.rx_hold = {8'h00, rx_byte};
                s_d.rx_ovf = s_q.rx_rdy && !bus_rd ? 1'b1 : s_d.rx_ovf;
                s_d.rx_rdy = 1'b1;
                s_d.rx_two = 1'b0;
            end else if (!s_q.rx_half) begin
                s_d.rx_hold = {rx_byte, 8'h00};
                s_d.rx_half = 1'b1;
            end else begin
                s_d.rx_hold = {s_q.rx_hold[15:8], rx_byte};
                s_d.rx_half = 1'b0;
                s_d.rx_ovf = s_q.rx_rdy && !bus_rd ? 1'b1 : s_d.rx_ovf;
                s_d.rx_rdy = 1'b1;
                s_d.rx_two = 1'b1;
            end
        end else if (rx_frame_end && s_q.rx_half) begin
            // A lone last byte, such as the check sequence tail, is released.
            s_d.rx_hold = {8'h00, s_q.rx_hold[15:8]};
            s_d.rx_half = 1'b0;
            s_d.rx_rdy = 1'b1;
            s_d.rx_two = 1'b0;
        end

        // General reset clears the receive ready and overflow flags and re-arms the width sample.
        if (gen_reset) begin
            s_d.am = AM_IDLE;
            s_d.rx_rdy = 1'b0;
            s_d.rx_ovf = 1'b0;
            s_d.rx_half = 1'b0;
            s_d.width_taken = 1'b0;
        end
    end

    // State register; transmit ready and idle line are high out of reset.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.tx_rdy <= 1'b1;
            s_q.tx_bit <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign bus_rdata = s_q.rdata;
    assign st_tx_ready = s_q.tx_rdy;
    assign st_rx_ready = s_q.rx_rdy;
    assign st_rx_overflow = s_q.rx_ovf;
    assign st_rx_two_chars = s_q.rx_two;
    assign am_event = s_q.event_p;
    assign am_cmd_pulse = s_q.cmd_p;
    assign am_rate_cap = s_q.cap;
    assign am_tone_off = s_q.tone_off;
    assign am_ec_fast = s_q.ec_fast;
    assign tx_bit = s_q.tx_bit;

    // Status code: progress, or the connected rate with the top bit set.
    always_comb begin
        case (s_q.am)
            AM_STARTUP: am_status = AST_STARTUP;
            AM_RETRAIN: am_status = AST_RETRAIN;
            AM_RENEG: am_status = AST_RENEG;
            AM_CONNECTED: am_status = {AST_CONNECTED_MSB, s_q.conn_rate};
            default: am_status = AST_IDLE;
        endcase
    end
endmodule

// >>> tb/amr_chk.sv
// Checker for command decode and rate reporting of the register group.
// Assumes it is bound to amr_regs and sees only that module's ports.
module amr_chk
    import amr_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_wr,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    // Modes and datapath.
    input wire logic [15:0] tx_mode_reg,
    input wire logic [15:0] rx_mode_reg,
    input wire logic dp_v32_family,
    input wire logic dp_train_done,
    input wire logic dp_train_fail,
    input wire logic [2:0] dp_rate,
    // Sequencer outputs.
    input wire logic [3:0] am_status,
    input wire logic am_event,
    input wire logic [4:0] am_cmd_pulse,
    input wire logic [2:0] am_rate_cap,
    input wire logic am_tone_off,
    input wire logic am_ec_fast
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // High for a command write while both modes select the auto modem.
    logic ok;
    assign ok = bus_wr && bus_addr == ADDR_AM_COMMAND
        && tx_mode_reg[15:12] == MODE_QAM_AUTO && rx_mode_reg[15:12] == MODE_QAM_AUTO;
    AST_EVENT: assert property (ok && bus_wdata[5:3] == 3'h2 && am_status == AST_IDLE
        |=> am_event && am_cmd_pulse == 5'h04 && am_status == AST_STARTUP)
        else $error("call from idle gave no start-up");
    AST_STOP: assert property (ok && bus_wdata[5:0] == CMD_STOP
        |=> am_cmd_pulse == 5'h01 && am_status == AST_IDLE)
        else $error("stop command not obeyed");
    AST_UNDEF: assert property (ok && bus_wdata[5:3] == 3'h0 && bus_wdata[2:0] != 3'h0
        |=> am_cmd_pulse == 5'h00)
        else $error("undefined command acted on");
    AST_IGNORE: assert property (bus_wr && bus_addr == ADDR_AM_COMMAND
        && rx_mode_reg[15:12] != MODE_QAM_AUTO |=> am_cmd_pulse == 5'h00)
        else $error("command obeyed outside auto mode");
    AST_CAP: assert property (ok && bus_wdata[5:4] == 2'h1
        |=> am_rate_cap == $past(bus_wdata[2:0]))
        else $error("rate cap not taken from command");
    AST_CONN: assert property (am_status == AST_STARTUP && dp_train_done
        && !dp_train_fail && !bus_wr |=> am_status[3] == 1'b1 && am_status[2:0]
        == (($past(dp_rate) < am_rate_cap) ? $past(dp_rate) : am_rate_cap))
        else $error("connected rate code wrong");
    AST_TONE: assert property (ok && bus_wdata[5:3] == 3'h7 && !dp_v32_family
        |=> am_tone_off)
        else $error("fast answer kept the answer tone");
    AST_EC: assert property (ok && bus_wdata[5:3] == 3'h6 && dp_v32_family
        |=> am_ec_fast)
        else $error("fast bit gave no quick echo training");
endmodule

bind amr_regs amr_chk u_chk (.clk, .reset, .bus_wr, .bus_addr, .bus_wdata, .tx_mode_reg,
    .rx_mode_reg, .dp_v32_family, .dp_train_done, .dp_train_fail, .dp_rate, .am_status,
    .am_event, .am_cmd_pulse, .am_rate_cap, .am_tone_off, .am_ec_fast);

// >>> tb/amr_host.sv
// Host model that reaches the registers with one-cycle word strobes.
// Assumes it changes the strobes at the falling edge of the block clock.
module amr_host
    import amr_pkg::*;
(
    // Clock and transmit ready flag.
    input wire logic clk,
    input wire logic tx_rdy,
    // Word strobes toward the block.
    output logic bus_wr = 1'b0,
    output logic bus_rd = 1'b0,
    output logic [7:0] bus_addr = 8'h00,
    output logic [15:0] bus_wdata = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Writes one word; data goes only while transmit room is reported.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        while (a != ADDR_AM_COMMAND && !tx_rdy) @(negedge clk);
        bus_addr = a;
        bus_wdata = (a == ADDR_AM_COMMAND) ? {10'h000, d[5:0]} : d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        bus_wdata = ~bus_wdata;
    endtask
    // Reads one word; the answer follows one cycle later.
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        bus_addr = ~a;
    endtask
endmodule

// >>> tb/amr_regs_tb.sv
// Self-checking bench for the auto-modem command and data registers.
// Assumes the host model drives the bus and the bench the datapath side.
module amr_regs_tb;
    import amr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset = 1'b1, wide = 1'b0, zero = 1'b0, v32 = 1'b0, done = 1'b0;
    logic tick = 1'b0, cs = 1'b0, bv = 1'b0, rb = 1'b0, fail = 1'b0, rem = 1'b0;
    logic [2:0] rate = 3'h0;
    logic [15:0] txm = 16'hF03F, rxm = 16'hF03F;
    logic bus_wr, bus_rd, tx_rdy, rx_rdy, tx_bit, tone, ecf;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [3:0] st;
    logic [4:0] pulse;
    logic [2:0] cap;
    int bad_count = 0, cmp_count = 0;
    typedef struct packed {logic [15:0] cmd; logic [4:0] p; logic [2:0] c;} amr_row_t;
    amr_row_t rows [4] = '{'{16'h0017, 5'h04, 3'h7}, '{16'h0000, 5'h01, 3'h7},
        '{16'h001A, 5'h08, 3'h2}, '{16'h0005, 5'h00, 3'h2}};
    amr_host host (.clk(clk), .tx_rdy(tx_rdy), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_addr(addr), .bus_wdata(wdata));
    amr_regs uut (.clk(clk), .reset(reset), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wide(wide),
        .bus_addr(addr), .bus_wdata(wdata), .bus_rdata(rdata), .tx_mode_reg(txm),
        .rx_mode_reg(rxm), .gen_wide_sel(wide), .gen_reset(zero), .st_tx_ready(tx_rdy),
        .st_rx_ready(rx_rdy), .st_rx_overflow(), .st_rx_two_chars(), .dp_v32_family(v32),
        .dp_train_done(done), .dp_train_fail(fail), .dp_rate(rate), .dp_remote_retrain(rem),
        .dp_remote_reneg(zero), .am_status(st), .am_event(), .am_cmd_pulse(pulse),
        .am_rate_cap(cap), .am_tone_off(tone), .am_ec_fast(ecf), .tx_bit_tick(tick),
        .tx_bit(tx_bit), .rx_char_start(cs), .rx_bit_valid(bv), .rx_bit(rb), .rx_frame_end(zero));
    // Compares one value and counts the outcome.
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Prints the verdict and stops the run.
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Clocks one byte out of the transmitter and checks each line bit.
    task automatic tx_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk) tick = 1'b1;
            @(negedge clk) tick = 1'b0;
            chk("tx_bit", 16'(tx_bit), 16'(b[i]));
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1000000;
        bad_count++;
        end_sim;
    end
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        chk("tx_ready", 16'(tx_rdy), 16'h1);
        chk("idle_bit", 16'(tx_bit), 16'h1);
        foreach (rows[i]) begin
            host.wr(ADDR_AM_COMMAND, rows[i].cmd);
            chk("cmd_pulse", 16'(pulse), 16'(rows[i].p));
            if (rows[i].p[3:2] != 2'h0) chk("rate_cap", 16'(cap), 16'(rows[i].c));
        end
        // Training ends faster than the cap allows, so the cap wins.
        rate = 3'h5;
        done = 1'b1;
        @(negedge clk) done = 1'b0;
        chk("status", 16'(st), 16'h000A);
        host.wr(ADDR_AM_COMMAND, 16'h000B);
        chk("retrain", 16'(pulse), 16'h0002);
        host.wr(ADDR_AM_COMMAND, 16'h0021);
        chk("reneg", 16'(pulse), 16'h0010);
        rxm = 16'h0000;
        host.wr(ADDR_AM_COMMAND, 16'h0017);
        chk("ignored", 16'(pulse), 16'h0000);
        rxm = 16'hF03F;
        host.wr(ADDR_AM_COMMAND, 16'h003F);
        chk("tone_off", 16'(tone), 16'h1);
        v32 = 1'b1;
        host.wr(ADDR_AM_COMMAND, 16'h0037);
        chk("ec_fast", 16'(ecf), 16'h1);
        // Failed re-negotiation capped at 4800 is retried at 2400.
        done = 1'b1;
        @(negedge clk) done = 1'b0;
        host.wr(ADDR_AM_COMMAND, 16'h0022);
        fail = 1'b1;
        @(negedge clk) fail = 1'b0;
        host.wr(ADDR_AM_COMMAND, 16'h0021);
        done = 1'b1;
        @(negedge clk) done = 1'b0;
        chk("reneg_low", 16'(st), 16'h0009);
        rem = 1'b1;
        @(negedge clk) rem = 1'b0;
        chk("remote", 16'(st), 16'h0002);
        host.wr(ADDR_TX_PRIMARY, 16'h00A5);
        repeat (3) @(negedge clk);
        tx_byte(8'hA5);
        wide = 1'b1;
        host.wr(ADDR_TX_PRIMARY, 16'h3C5A);
        repeat (3) @(negedge clk);
        tx_byte(8'h3C);
        tx_byte(8'h5A);
        // Width was taken at reset, so one character completes a read.
        @(negedge clk) cs = 1'b1;
        @(negedge clk) cs = 1'b0;
        bv = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rb = i[0] ^ i[2];
            @(negedge clk);
        end
        bv = 1'b0;
        @(negedge clk);
        chk("rx_ready", 16'(rx_rdy), 16'h1);
        host.rd(ADDR_RX_DATA);
        chk("rx_data", rdata, 16'h005A);
        chk("rx_clear", 16'(rx_rdy), 16'h0);
        end_sim;
    end
endmodule
